// File: pkg/csw_pkg.sv
// Constants, codes and reset decoding shared by the clock switch register block
package csw_pkg;

   // ==========================================================
   // Register indices (byte address = 4 * index)
   localparam logic [13:0] IDX_EVT_STATUS = 14'hed0;
   localparam logic [13:0] IDX_EVT_MASK   = 14'hed1;
   localparam logic [13:0] IDX_REQUEST    = 14'hed3;
   localparam logic [13:0] IDX_ACTIVE     = 14'hed4;
   localparam logic [13:0] IDX_SWCTRL     = 14'hed5;
   localparam logic [13:0] IDX_OSCRDY     = 14'hed6;

   // ==========================================================
   // Field positions
   localparam int SRC_MSB        = 6;
   localparam int SRC_LSB        = 4;
   localparam int DIV_MSB        = 3;
   localparam int HOLD_BIT       = 7;
   localparam int SPWR_BIT       = 6;
   localparam int EVT_SWITCH_BIT = 0;
   localparam int EVT_DONE_BIT   = 1;

   // ==========================================================
   // Source codes and divider limits
   typedef enum logic [2:0] {
      src_rsvd0     = 3'h0,
      src_rsvd1     = 3'h1,
      src_ext_mult  = 3'h2,
      src_rsvd3     = 3'h3,
      src_secondary = 3'h4,
      src_slow_int  = 3'h5,
      src_fast_int  = 3'h6,
      src_external  = 3'h7
   } csw_src_type;

   localparam logic [3:0] DIV_MAX      = 4'h9;
   localparam logic [3:0] DIV_RST_ONE  = 4'h0;
   localparam logic [3:0] DIV_RST_FOUR = 4'h2;
   localparam logic [3:0] FRQ_RST_4M   = 4'h2;
   localparam logic [3:0] FRQ_RST_64M  = 4'h8;
   localparam logic [7:0] SWCTRL_RST   = 8'h00;
   localparam logic [1:0] EVT_RST      = 2'h0;

   // Reserved source codes are refused on write
   function automatic logic csw_src_reserved(input logic [2:0] code);
      csw_src_reserved = (code == src_rsvd0) || (code == src_rsvd1) || (code == src_rsvd3);
   endfunction : csw_src_reserved

   // Reset source: reserved strap codes fall back to the fast oscillator
   function automatic logic [2:0] csw_rst_src(input logic [2:0] cfg);
      csw_rst_src = (csw_src_reserved(cfg)) ? src_fast_int : cfg;
   endfunction : csw_rst_src

   function automatic logic [3:0] csw_rst_div(input logic [2:0] cfg);
      csw_rst_div = (cfg == src_fast_int || csw_src_reserved(cfg) && cfg != src_rsvd0)
                    ? DIV_RST_FOUR : DIV_RST_ONE;
   endfunction : csw_rst_div

   function automatic logic [3:0] csw_rst_frq(input logic [2:0] cfg);
      csw_rst_frq = (cfg == src_rsvd0) ? FRQ_RST_64M : FRQ_RST_4M;
   endfunction : csw_rst_frq

endpackage : csw_pkg

// File: pkg/csw_switch_if.sv
// Link between the register front end and the switch sequencer
`timescale 1ns/1ps

interface csw_switch_if;
   logic [2:0] req_src;
   logic [3:0] req_div;
   logic [2:0] rst_src;
   logic [3:0] rst_div;
   logic       hold;
   logic       target_ok;
   logic [2:0] act_src;
   logic [3:0] act_div;
   logic       target_ready;
   logic       complete;
   logic       take_switch;

   modport ctrl (
      output req_src, req_div, rst_src, rst_div, hold, target_ok,
      input  act_src, act_div, target_ready, complete, take_switch
   );
   modport seq (
      input  req_src, req_div, rst_src, rst_div, hold, target_ok,
      output act_src, act_div, target_ready, complete, take_switch
   );
endinterface : csw_switch_if

// File: hw/csw_switch_seq.sv
// Switch sequencer: holds the active source and divider and decides the switch
`timescale 1ns/1ps

module csw_switch_seq
   import csw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   csw_switch_if.seq sw
);

   logic [2:0] next_act_src;
   logic [3:0] next_act_div;
   logic       pending;

   // ==========================================================
   // Switch decision
   always_comb begin
      pending         = {sw.req_src, sw.req_div} != {sw.act_src, sw.act_div};
      // R11: complete when request equals active
      sw.complete     = !pending;
      // R12: ready only while pending
      sw.target_ready = pending && sw.target_ok;
      // R9: switch once ready, unless held
      sw.take_switch  = sw.target_ready && !sw.hold;
      // R16: stay on the old clock until ready
      next_act_src    = sw.take_switch ? sw.req_src : sw.act_src;
      next_act_div    = sw.take_switch ? sw.req_div : sw.act_div;
   end

   // R13: ready flag lasts one cycle when not held
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sw.act_src <= sw.rst_src;
         sw.act_div <= sw.rst_div;
      end else begin
         sw.act_src <= next_act_src;
         sw.act_div <= next_act_div;
      end
   end

   // ==========================================================
   // Checks
   a_switch_go: assert property (@(posedge clk) disable iff (!rst_n) // R9
      sw.target_ready && !sw.hold |=> {sw.act_src, sw.act_div} == $past({sw.req_src, sw.req_div}))
      else $error("switch not taken when ready and not held");
   a_ready_pending: assert property (@(posedge clk) disable iff (!rst_n) // R12
      sw.target_ready |-> sw.target_ok && !sw.complete)
      else $error("target ready without pending ready switch");

endmodule : csw_switch_seq

// File: hw/csw_clock_switch_regs.sv
// Clock switch control and status registers behind a classic Wishbone slave
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps

// ==========================================================
// Summary of operation
// R1: Source codes 111,110,101,100,010; others reserved
// R2: Divider code n divides by 2^n, max 9; codes above 9 are stored as written
// R3: Reserved source write leaves source unchanged
// R4: Permit strap low makes request read-only
// R5: Reset loads fields from reset source strap
// R6: Active source and divider are read-only
// R7: After reset active equals requested
// R8: Hold set suspends ready switch, raises event
// R9: Hold clear switches as soon as ready
// R10: Secondary power bit selects high power, resets 0
// R11: Complete flag set when request equals active
// R12: Target ready while pending and source ready
// R13: Unheld target ready lasts one cycle only
// R14: Status bits show each oscillator ready
// R15: Multiplier ready needs enable, input, lock
// R16: Old clock runs until target ready
// R17: Event flag sets with target ready
// R18: Switch updates active, completes, drops ready
// R19: Unused bits read zero, ignore writes
module csw_clock_switch_regs
   import csw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [15:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [2:0]  reset_source_config,
   input  wire logic        switch_permit_config,
   input  wire logic        external_osc_ready,
   input  wire logic        fast_internal_osc_ready,
   input  wire logic        medium_internal_osc_ready,
   input  wire logic        slow_internal_osc_ready,
   input  wire logic        secondary_osc_ready,
   input  wire logic        converter_osc_ready,
   input  wire logic        multiplier_locked,
   input  wire logic        hold_clear_req,
   output logic      [2:0]  active_source_ind,
   output logic      [3:0]  active_divider_ind,
   output logic             secondary_osc_power_sel,
   output logic      [3:0]  fast_osc_freq_sel,
   output logic             multiplier_enable,
   output logic             switch_irq
);

   // ==========================================================
   // Declarations
   logic [2:0]  requested_source_sel;
   logic [3:0]  requested_divider_sel;
   logic        switch_hold;
   logic [1:0]  evt_status;
   logic [1:0]  evt_mask;
   logic        trdy_q;
   logic [2:0]  next_req_src;
   logic [3:0]  next_req_div;
   logic        next_hold;
   logic        next_spwr;
   logic [1:0]  next_evt;
   logic [1:0]  next_mask;
   logic        next_trdy_q;
   logic        next_ack;
   logic [31:0] next_dat;
   logic [7:0]  rd_byte;
   logic [13:0] reg_idx;
   logic        wb_hit;
   logic        wr_commit;
   logic        wr_req;
   logic        wr_ctrl;
   logic        wr_evt;
   logic        wr_mask;
   logic        multiplier_lock_ready;
   logic [1:0]  evt_set;
   logic        mapped;

   csw_switch_if sw ();

   // ==========================================================
   // Switch sequencer
   csw_switch_seq u_seq (
      .clk   (clk),
      .rst_n (rst_n),
      .sw    (sw)
   );

   // R6: active fields come only from the sequencer
   assign active_source_ind  = sw.act_src;
   assign active_divider_ind = sw.act_div;

   // ==========================================================
   // Oscillator readiness
   always_comb begin
      // The multiplier runs while either side of a switch uses it
      multiplier_enable = (requested_source_sel == src_ext_mult) ||
                          (sw.act_src == src_ext_mult);
      // R15: needs enable, ready input and lock
      multiplier_lock_ready = multiplier_enable && external_osc_ready && multiplier_locked;
      // R1: ready of the requested source
      unique case (requested_source_sel)
         src_external:  sw.target_ok = external_osc_ready;
         src_fast_int:  sw.target_ok = fast_internal_osc_ready;
         src_slow_int:  sw.target_ok = slow_internal_osc_ready;
         src_secondary: sw.target_ok = secondary_osc_ready;
         src_ext_mult:  sw.target_ok = multiplier_lock_ready;
         default:       sw.target_ok = 1'b0;
      endcase
   end

   assign sw.req_src = requested_source_sel;
   assign sw.req_div = requested_divider_sel;
   assign sw.hold    = switch_hold;
   // R5: reset values decoded from the strap
   assign sw.rst_src = csw_rst_src(reset_source_config);
   assign sw.rst_div = csw_rst_div(reset_source_config);

   // ==========================================================
   // Bus decode
   // Writes land on the edge where the master sees ack, so a
   // write and its ack are never split across two edges.
   always_comb begin
      reg_idx   = wb_adr_i[15:2];
      wb_hit    = wb_cyc_i && wb_stb_i;
      wr_commit = wb_hit && wb_we_i && wb_ack_o && wb_sel_i[0];
      // R4: request is read-only without permit
      wr_req    = wr_commit && (reg_idx == IDX_REQUEST) && switch_permit_config;
      wr_ctrl   = wr_commit && (reg_idx == IDX_SWCTRL);
      wr_evt    = wr_commit && (reg_idx == IDX_EVT_STATUS);
      wr_mask   = wr_commit && (reg_idx == IDX_EVT_MASK);
      mapped    = (reg_idx == IDX_REQUEST) || (reg_idx == IDX_ACTIVE) ||
                  (reg_idx == IDX_SWCTRL) || (reg_idx == IDX_OSCRDY) ||
                  (reg_idx == IDX_EVT_STATUS) || (reg_idx == IDX_EVT_MASK);
   end

   // ==========================================================
   // Read mux
   always_comb begin
      // R19: unused bits and unmapped words read zero
      rd_byte = 8'h00;
      case (reg_idx)
         IDX_REQUEST:    rd_byte = {1'b0, requested_source_sel, requested_divider_sel};
         IDX_ACTIVE:     rd_byte = {1'b0, sw.act_src, sw.act_div};
         IDX_SWCTRL:     rd_byte = {switch_hold, secondary_osc_power_sel, 1'b0,
                                    sw.complete, sw.target_ready, 3'h0};
         // R14: live ready flags of each oscillator
         IDX_OSCRDY:     rd_byte = {external_osc_ready, fast_internal_osc_ready,
                                    medium_internal_osc_ready, slow_internal_osc_ready,
                                    secondary_osc_ready, converter_osc_ready, 1'b0,
                                    multiplier_lock_ready};
         IDX_EVT_STATUS: rd_byte = {6'h00, evt_status};
         IDX_EVT_MASK:   rd_byte = {6'h00, evt_mask};
         default:        rd_byte = 8'h00;
      endcase
   end

   // ==========================================================
   // Next values of software visible state, except the active fields held by the sequencer
   always_comb begin
      next_req_src = requested_source_sel;
      next_req_div = requested_divider_sel;
      next_hold    = switch_hold;
      next_spwr    = secondary_osc_power_sel;
      next_mask    = evt_mask;
      next_trdy_q  = sw.target_ready;
      next_ack     = wb_hit && !wb_ack_o;
      next_dat     = wb_ack_o ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      if (wr_req) begin
         // R3: a reserved source code is dropped
         if (!csw_src_reserved(wb_dat_i[SRC_MSB:SRC_LSB])) begin
            next_req_src = wb_dat_i[SRC_MSB:SRC_LSB];
         end
         // R2: divider code stored as written
         next_req_div = wb_dat_i[DIV_MSB:0];
      end
      // R8: software writes hold, hardware may clear it
      if (wr_ctrl) begin
         next_hold = wb_dat_i[HOLD_BIT];
         // R10: secondary oscillator power mode
         next_spwr = wb_dat_i[SPWR_BIT];
      end else if (hold_clear_req) begin
         next_hold = 1'b0;
      end
      if (wr_mask) begin
         next_mask = wb_dat_i[1:0];
      end
      // R17: event on the rising edge of target ready
      evt_set = '0;
      evt_set[EVT_SWITCH_BIT] = sw.target_ready && !trdy_q;
      // R18: completion event on the switch itself
      evt_set[EVT_DONE_BIT]   = sw.take_switch;
      // Set beats a write-one clear landing in the same cycle
      next_evt = (evt_status & ~(wr_evt ? wb_dat_i[1:0] : 2'h0)) | evt_set;
   end

   // ==========================================================
   // State registers
   // R7: request and active load the same reset values
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         requested_source_sel    <= csw_rst_src(reset_source_config);
         requested_divider_sel   <= csw_rst_div(reset_source_config);
         fast_osc_freq_sel       <= csw_rst_frq(reset_source_config);
         switch_hold             <= SWCTRL_RST[HOLD_BIT];
         secondary_osc_power_sel <= SWCTRL_RST[SPWR_BIT];
         evt_status              <= EVT_RST;
         evt_mask                <= EVT_RST;
         trdy_q                  <= 1'b0;
         wb_ack_o                <= 1'b0;
         wb_dat_o                <= 32'h0000_0000;
      end else begin
         requested_source_sel    <= next_req_src;
         requested_divider_sel   <= next_req_div;
         switch_hold             <= next_hold;
         secondary_osc_power_sel <= next_spwr;
         evt_status              <= next_evt;
         evt_mask                <= next_mask;
         trdy_q                  <= next_trdy_q;
         wb_ack_o                <= next_ack;
         wb_dat_o                <= next_dat;
      end
   end

   // Level interrupt while any unmasked event is pending
   assign switch_irq = |(evt_status & evt_mask);

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_reset_load: assert property ( // R5
      $rose(rst_n) |-> requested_source_sel == csw_rst_src(reset_source_config)
                    && {sw.act_src, sw.act_div} == {requested_source_sel, requested_divider_sel})
      else $error("reset values not loaded from strap");

   a_reserved_src_kept: assert property ( // R3
      wr_req && csw_src_reserved(wb_dat_i[SRC_MSB:SRC_LSB])
      |=> requested_source_sel == $past(requested_source_sel))
      else $error("reserved source code was stored");

   a_permit_lock: assert property ( // R4
      !switch_permit_config && wr_commit
      |=> $stable({requested_source_sel, requested_divider_sel}))
      else $error("request changed without permit");

   a_hold_blocks: assert property ( // R8
      switch_hold && sw.target_ready |=> $stable({sw.act_src, sw.act_div}))
      else $error("held switch was taken");

   a_event_sets: assert property ( // R17
      $rose(sw.target_ready) |=> evt_status[EVT_SWITCH_BIT])
      else $error("switch event not flagged");

   a_switch_effect: assert property ( // R18
      sw.take_switch && !wr_req |=> sw.complete && !sw.target_ready)
      else $error("switch did not complete cleanly");

   a_mult_ready: assert property ( // R15
      multiplier_lock_ready |-> multiplier_locked && external_osc_ready && multiplier_enable)
      else $error("multiplier ready without lock");

   a_unmapped_zero: assert property ( // R19
      wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   // ==========================================================
   // Register and flag checks
   // Neither register may ever hold a reserved source code
   a_source_legal: assert property ( // R1
      !csw_src_reserved(requested_source_sel) && !csw_src_reserved(sw.act_src))
      else $error("reserved source code held");

   // Every divider code is stored as written, reserved ones too
   a_divider_stored: assert property ( // R2
      wr_req |=> requested_divider_sel == $past(wb_dat_i[DIV_MSB:0]))
      else $error("divider write not stored");

   // Software has no path to the active fields
   a_active_ro: assert property ( // R6
      !sw.take_switch |=> $stable({sw.act_src, sw.act_div}))
      else $error("active fields changed without a switch");

   // Power select follows its control write
   a_power_write: assert property ( // R10
      wr_ctrl |=> secondary_osc_power_sel == $past(wb_dat_i[SPWR_BIT]))
      else $error("power select write not stored");

   // Complete flag is the comparison of both registers
   a_complete_flag: assert property ( // R11
      sw.complete == ({requested_source_sel, requested_divider_sel} ==
                      {sw.act_src, sw.act_div}))
      else $error("complete flag disagrees with registers");

   // Polling software cannot rely on seeing the unheld ready flag
   a_ready_short: assert property ( // R13
      sw.target_ready && !switch_hold && !wr_req |=> !sw.target_ready)
      else $error("unheld target ready lasted more than one cycle");

   // Ready bits are read live, one cycle before the answer
   a_osc_ready_map: assert property ( // R14
      wb_ack_o && $past(reg_idx) == IDX_OSCRDY
      |-> wb_dat_o[7:1] == $past({external_osc_ready, fast_internal_osc_ready,
                                  medium_internal_osc_ready, slow_internal_osc_ready,
                                  secondary_osc_ready, converter_osc_ready, 1'b0}))
      else $error("ready status read wrong");

   // Old clock stays while the target is not ready
   a_old_clock: assert property ( // R16
      !sw.target_ok |=> $stable({sw.act_src, sw.act_div}))
      else $error("switched to a source that was not ready");

   // Switch event stays until software writes a one to it
   a_event_sticky: assert property ( // R17
      evt_status[EVT_SWITCH_BIT] && !wr_evt |=> evt_status[EVT_SWITCH_BIT])
      else $error("switch event lost without a clear");

   // An enabled switch event drives the interrupt
   a_irq_level: assert property ( // R17
      evt_status[EVT_SWITCH_BIT] && evt_mask[EVT_SWITCH_BIT] |-> switch_irq)
      else $error("unmasked switch event without interrupt");

   // Hardware clear of hold loses only to a software write
   a_hold_hw_clear: assert property ( // R8
      hold_clear_req && !wr_ctrl |=> !switch_hold)
      else $error("hold not cleared by hardware");

   // Upper data lanes are never used
   a_upper_zero: assert property ( // R19
      wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read data not zero");

   c_held_switch: cover property ((switch_hold && sw.target_ready) [*3]);
   c_hold_cleared: cover property ($fell(switch_hold));
   c_switch_done: cover property (sw.take_switch);
   c_irq_raised:  cover property ($rose(switch_irq));
   c_reserved_wr: cover property (wr_req && csw_src_reserved(wb_dat_i[SRC_MSB:SRC_LSB]));

endmodule : csw_clock_switch_regs

// File: testbench/csw_clock_switch_regs_tb.sv
// Self-checking bench for the clock switch register block
`timescale 1ns/1ps

module csw_clock_switch_regs_tb
   import csw_pkg::*;
;
   // ==========================================================
   // Stimulus and observation signals
   logic        clk    = 1'b0;
   logic        rst_n  = 1'b0;
   logic        cyc    = 1'b0;
   logic        stb    = 1'b0;
   logic        we     = 1'b0;
   logic [15:0] adr    = 16'h0000;
   logic [3:0]  sel    = 4'h0;
   logic [31:0] dat    = 32'h0000_0000;
   logic [2:0]  strap  = 3'h6;
   logic        permit = 1'b1;
   logic [7:0]  rdy    = 8'hfd;  // Bit layout of the ready status, bit 0 is lock
   logic        hclr   = 1'b0;
   logic [31:0] dat_o;
   logic        ack;
   logic [2:0]  a_src;
   logic [3:0]  a_div;
   logic [3:0]  frq;
   logic        spwr;
   logic        m_en;
   logic        irq;
   int          n_fail     = 0;
   int          num_checks = 0;

   // Free-running 100 MHz clock
   always #5 clk = ~clk;

   csw_clock_switch_regs dut (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .reset_source_config(strap), .switch_permit_config(permit),
      .external_osc_ready(rdy[7]), .fast_internal_osc_ready(rdy[6]),
      .medium_internal_osc_ready(rdy[5]), .slow_internal_osc_ready(rdy[4]),
      .secondary_osc_ready(rdy[3]), .converter_osc_ready(rdy[2]),
      .multiplier_locked(rdy[0]), .hold_clear_req(hclr),
      .active_source_ind(a_src), .active_divider_ind(a_div),
      .secondary_osc_power_sel(spwr), .fast_osc_freq_sel(frq),
      .multiplier_enable(m_en), .switch_irq(irq));

   // ==========================================================
   // Shared tasks
   task automatic end_sim;
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One classic cycle; request held until ack is sampled high, released at that edge
   task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] wd,
                     output logic [31:0] rdv);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      sel <= 4'h1;
      adr <= {idx, 2'b00};
      dat <= {24'h0, wd};
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      rdv = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (n == 20) begin
         chk("bus ack", 32'h0, 32'h1);
         end_sim();
      end
   endtask : wb

   task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
      logic [31:0] unused;
      wb(1'b1, idx, wd, unused);
   endtask : wr

   task automatic rdchk(input logic [13:0] idx, input logic [7:0] exp, input string what);
      logic [31:0] v;
      wb(1'b0, idx, 8'h00, v);
      chk(what, v, {24'h0, exp});
   endtask : rdchk

   // Bounded wait for the active source pins to reach a value
   task automatic wait_src(input logic [2:0] s);
      int n;
      for (n = 0; n < 20 && a_src !== s; n++) @(posedge clk);
      chk("active source pins", {29'h0, a_src}, {29'h0, s});
      if (a_src !== s) end_sim();
   endtask : wait_src

   // Straps settle before the synchronous reset is applied for two edges
   task automatic do_reset(input logic [2:0] s, input logic p);
      @(posedge clk);
      strap <= s;
      permit <= p;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask : do_reset

   // ==========================================================
   // Scenarios
   task automatic t_straps;
      logic [2:0] s;
      logic [7:0] e;
      for (int i = 0; i < 8; i++) begin
         s = 3'(i);
         e[7:4] = (s == 3'h0 || s == 3'h1 || s == 3'h3) ? 4'h6 : {1'b0, s};
         e[3:0] = (s == 3'h6 || s == 3'h1 || s == 3'h3) ? 4'h2 : 4'h0;
         do_reset(s, 1'b1);
         rdchk(IDX_REQUEST, e, "request after reset");
         rdchk(IDX_ACTIVE, e, "active after reset");
         chk("freq select", {28'h0, frq}, (s == 3'h0) ? 32'h8 : 32'h2);
      end
   endtask : t_straps

   task automatic t_status;
      do_reset(3'h6, 1'b1);
      rdchk(IDX_SWCTRL, 8'h10, "ctrl after reset");
      rdy <= 8'ha9;
      rdchk(IDX_OSCRDY, 8'ha8, "ready pattern");
   endtask : t_status

   task automatic t_free;
      rdy <= 8'hed;
      wr(IDX_EVT_MASK, 8'h03);
      wr(IDX_REQUEST, 8'h53);
      rdchk(IDX_ACTIVE, 8'h62, "old clock kept");
      rdchk(IDX_SWCTRL, 8'h00, "switch pending");
      rdy <= 8'hfd;
      wait_src(3'h5);
      rdchk(IDX_ACTIVE, 8'h53, "active after switch");
      rdchk(IDX_SWCTRL, 8'h10, "ready flag hidden");
      rdchk(IDX_EVT_STATUS, 8'h03, "events");
      chk("irq set", {31'h0, irq}, 32'h1);
      wr(IDX_EVT_STATUS, 8'h03);
      rdchk(IDX_EVT_STATUS, 8'h00, "events cleared");
      chk("irq clear", {31'h0, irq}, 32'h0);
   endtask : t_free

   task automatic t_hold;
      rdy <= 8'hf5;
      wr(IDX_SWCTRL, 8'h80);
      wr(IDX_REQUEST, 8'h41);
      rdchk(IDX_SWCTRL, 8'h80, "target not ready");
      rdy <= 8'hfd;
      rdchk(IDX_SWCTRL, 8'h88, "held and ready");
      rdchk(IDX_ACTIVE, 8'h53, "held switch");
      rdchk(IDX_EVT_STATUS, 8'h01, "held event");
      chk("irq held", {31'h0, irq}, 32'h1);
      wr(IDX_EVT_STATUS, 8'h01);
      @(posedge clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      @(posedge clk);
      hclr <= 1'b1;
      @(posedge clk);
      hclr <= 1'b0;
      wait_src(3'h4);
      rdchk(IDX_ACTIVE, 8'h41, "active after release");
      rdchk(IDX_SWCTRL, 8'h10, "hold cleared by hardware");
      rdchk(IDX_EVT_STATUS, 8'h02, "switch taken event");
      wr(IDX_EVT_STATUS, 8'h02);
   endtask : t_hold

   task automatic t_reserved;
      logic [2:0] codes[3] = '{3'h0, 3'h1, 3'h3};
      for (int i = 0; i < 3; i++) begin
         wr(IDX_REQUEST, {1'b0, codes[i], 4'(i + 5)});
         rdchk(IDX_REQUEST, {4'h4, 4'(i + 5)}, "reserved source dropped");
      end
   endtask : t_reserved

   task automatic t_mult_ro;
      rdy <= 8'hfc;
      wr(IDX_REQUEST, 8'h29);
      @(posedge clk);
      chk("multiplier enable", {31'h0, m_en}, 32'h1);
      rdchk(IDX_OSCRDY, 8'hfc, "multiplier unlocked");
      rdy <= 8'hfd;
      rdchk(IDX_OSCRDY, 8'hfd, "multiplier locked");
      wait_src(3'h2);
      chk("active divider pins", {28'h0, a_div}, 32'h9);
      wr(IDX_ACTIVE, 8'h00);
      rdchk(IDX_ACTIVE, 8'h29, "active read-only");
      wr(IDX_SWCTRL, 8'hff);
      rdchk(IDX_SWCTRL, 8'hd0, "ctrl unused bits");
      chk("power select", {31'h0, spwr}, 32'h1);
      wr(IDX_SWCTRL, 8'h00);
      wr(IDX_OSCRDY, 8'h00);
      rdchk(IDX_OSCRDY, 8'hfd, "ready read-only");
      wr(IDX_REQUEST, 8'hf0);
      rdchk(IDX_REQUEST, 8'h70, "request bit 7");
      rdchk(14'hee0, 8'h00, "unmapped read");
   endtask : t_mult_ro

   task automatic t_permit;
      do_reset(3'h6, 1'b0);
      wr(IDX_REQUEST, 8'h53);
      rdchk(IDX_REQUEST, 8'h62, "request locked");
      rdchk(IDX_ACTIVE, 8'h62, "active locked");
   endtask : t_permit

   // ==========================================================
   // Main sequence
   initial begin
      t_straps();
      t_status();
      t_free();
      t_hold();
      t_reserved();
      t_mult_ro();
      t_permit();
      end_sim();
   end
endmodule : csw_clock_switch_regs_tb
